// file: logic/pbcf_pkg.sv
package pbcf_pkg;
  // bus command codes
  localparam logic [3:0] CMD_INTACK = 4'h0;
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IORD = 4'h2;
  localparam logic [3:0] CMD_IOWR = 4'h3;
  localparam logic [3:0] CMD_RSV4 = 4'h4;
  localparam logic [3:0] CMD_RSV5 = 4'h5;
  localparam logic [3:0] CMD_MEMRD = 4'h6;
  localparam logic [3:0] CMD_MEMWR = 4'h7;
  localparam logic [3:0] CMD_RSV8 = 4'h8;
  localparam logic [3:0] CMD_RSV9 = 4'h9;
  localparam logic [3:0] CMD_CFGRD = 4'hA;
  localparam logic [3:0] CMD_CFGWR = 4'hB;
  localparam logic [3:0] CMD_MEMRDM = 4'hC;
  localparam logic [3:0] CMD_DAC = 4'hD;
  localparam logic [3:0] CMD_MEMRDL = 4'hE;
  localparam logic [3:0] CMD_MEMWRI = 4'hF;
  // buffer geometry: 128 bytes of 32-bit words
  localparam int BUF_BYTES = 128;
  localparam int BUF_WORDS = BUF_BYTES / 4;
  localparam int BUF_AW = $clog2(BUF_WORDS);
  // entry layout: address, data, command, byte enables
  localparam int ENT_W = 32 + 32 + 4 + 4;
  localparam int ENT_ADDR_LSB = 40;
  localparam int ENT_DATA_LSB = 8;
  localparam int ENT_CMD_LSB = 4;
  localparam int ENT_BE_LSB = 0;
  // config address type field in AD[1:0]
  localparam logic [1:0] CFG_TYPE1 = 2'h1;
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  // directions
  localparam int DIR_DOWN = 0;
  localparam int DIR_UP = 1;
  // forwarding kinds
  typedef enum logic [1:0] {
    PBCF_FWD_NONE,
    PBCF_FWD_POSTED,
    PBCF_FWD_DELAYED,
    PBCF_FWD_READ
  } pbcf_fwd_t;
endpackage

// file: logic/pbcf_filter.sv
`timescale 1ns/100ps
module pbcf_filter (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic priAddrPhase,
  input wire logic [3:0] priCmd,
  input wire logic [31:0] priAddr,
  input wire logic priDecodeHit,
  input wire logic priVgaHit,
  input wire logic [31:0] priData,
  input wire logic [3:0] priByteEn,
  input wire logic priDataValid,
  input wire logic secAddrPhase,
  input wire logic [3:0] secCmd,
  input wire logic [31:0] secAddr,
  input wire logic secDecodeHit,
  input wire logic secVgaHit,
  input wire logic [31:0] secData,
  input wire logic [3:0] secByteEn,
  input wire logic secDataValid,
  input wire logic [3:0] priIssueCmd,
  input wire logic [1:0] priIssueAddrLo,
  input wire logic [3:0] secIssueCmd,
  input wire logic [1:0] secIssueAddrLo,
  input wire logic downPop,
  input wire logic upPop,
  output logic priClaim,
  output logic secClaim,
  output logic priDevselOff,
  output logic secDevselOff,
  output logic priDisconnect,
  output logic secDisconnect,
  output pbcf_pkg::pbcf_fwd_t priFwd,
  output pbcf_pkg::pbcf_fwd_t secFwd,
  output logic priIssueOk,
  output logic secIssueOk,
  output logic priSpecialConv,
  output logic downFull,
  output logic upFull,
  output logic downValid,
  output logic upValid,
  output logic [71:0] downEntry,
  output logic [71:0] upEntry
);

  // target acceptance per command and bus
  function automatic logic tgtOk(input logic [3:0] c, input logic isPri,
                                 input logic [1:0] lo);
    unique case (c)
      pbcf_pkg::CMD_IORD, pbcf_pkg::CMD_IOWR: tgtOk = 1'b1;
      pbcf_pkg::CMD_MEMRD, pbcf_pkg::CMD_MEMWR, pbcf_pkg::CMD_MEMRDM,
      pbcf_pkg::CMD_DAC, pbcf_pkg::CMD_MEMRDL,
      pbcf_pkg::CMD_MEMWRI: tgtOk = 1'b1;
      pbcf_pkg::CMD_CFGRD: tgtOk = isPri;
      pbcf_pkg::CMD_CFGWR:
        tgtOk = isPri || (lo == pbcf_pkg::CFG_TYPE1);
      pbcf_pkg::CMD_SPECIAL: tgtOk = 1'b0;
      pbcf_pkg::CMD_INTACK: tgtOk = 1'b0;
      default: tgtOk = 1'b0; // reserved codes ignored
    endcase
  endfunction

  // master issue permission per command and bus
  function automatic logic mstOk(input logic [3:0] c, input logic isPri,
                                 input logic [1:0] lo);
    unique case (c)
      pbcf_pkg::CMD_SPECIAL: mstOk = 1'b1;
      pbcf_pkg::CMD_IORD, pbcf_pkg::CMD_IOWR: mstOk = 1'b1;
      pbcf_pkg::CMD_MEMRD, pbcf_pkg::CMD_MEMWR, pbcf_pkg::CMD_MEMRDM,
      pbcf_pkg::CMD_DAC, pbcf_pkg::CMD_MEMRDL,
      pbcf_pkg::CMD_MEMWRI: mstOk = 1'b1;
      pbcf_pkg::CMD_CFGRD: mstOk = !isPri;
      pbcf_pkg::CMD_CFGWR:
        mstOk = !isPri || (lo == pbcf_pkg::CFG_TYPE1);
      pbcf_pkg::CMD_INTACK: mstOk = 1'b0;
      default: mstOk = 1'b0;
    endcase
  endfunction

  // forwarding kind of a claimed command
  function automatic pbcf_pkg::pbcf_fwd_t fwdOf(input logic [3:0] c,
                                                 input logic vga);
    unique case (c)
      pbcf_pkg::CMD_MEMWR:
        fwdOf = vga ? pbcf_pkg::PBCF_FWD_DELAYED
                    : pbcf_pkg::PBCF_FWD_POSTED;
      pbcf_pkg::CMD_MEMWRI: fwdOf = pbcf_pkg::PBCF_FWD_POSTED;
      pbcf_pkg::CMD_IOWR, pbcf_pkg::CMD_CFGWR:
        fwdOf = pbcf_pkg::PBCF_FWD_DELAYED;
      default: fwdOf = pbcf_pkg::PBCF_FWD_READ;
    endcase
  endfunction

  // master side checks are combinational gates on the issue path
  assign priIssueOk = mstOk(priIssueCmd, 1'b1, priIssueAddrLo);
  assign secIssueOk = mstOk(secIssueCmd, 1'b0, secIssueAddrLo);

  // address phase capture state
  logic priClaim_q, priClaim_d, secClaim_q, secClaim_d;
  logic priDisc_q, priDisc_d, secDisc_q, secDisc_d;
  logic [3:0] priCmd_q, priCmd_d, secCmd_q, secCmd_d;
  logic [31:0] priAddr_q, priAddr_d, secAddr_q, secAddr_d;
  pbcf_pkg::pbcf_fwd_t priFwd_q, priFwd_d, secFwd_q, secFwd_d;

  // type 1 config write from primary with AD[15:8] = FF carries a special cycle request
  assign priSpecialConv = priClaim && (priCmd_q == pbcf_pkg::CMD_CFGWR)
    && (priAddr_q[1:0] == pbcf_pkg::CFG_TYPE1)
    && (priAddr_q[15:8] == 8'hFF);

  // classify on the address phase, hold until the next one
  always_comb begin
    priClaim_d = priClaim_q;
    secClaim_d = secClaim_q;
    priDisc_d = priDisc_q;
    secDisc_d = secDisc_q;
    priCmd_d = priCmd_q;
    secCmd_d = secCmd_q;
    priAddr_d = priAddr_q;
    secAddr_d = secAddr_q;
    priFwd_d = priFwd_q;
    secFwd_d = secFwd_q;
    if (priAddrPhase) begin
      priCmd_d = priCmd;
      priAddr_d = priAddr;
      priClaim_d = priDecodeHit && tgtOk(priCmd, 1'b1, priAddr[1:0]);
      priFwd_d = fwdOf(priCmd, priVgaHit);
      priDisc_d = (priAddr[1:0] != 2'h0) && priCmd != pbcf_pkg::CMD_CFGWR
        && priCmd != pbcf_pkg::CMD_CFGRD;
    end
    if (secAddrPhase) begin
      secCmd_d = secCmd;
      secAddr_d = secAddr;
      secClaim_d = secDecodeHit && tgtOk(secCmd, 1'b0, secAddr[1:0]);
      secFwd_d = fwdOf(secCmd, secVgaHit);
      secDisc_d = (secAddr[1:0] != 2'h0) && secCmd != pbcf_pkg::CMD_CFGWR;
    end
  end

  // register the classification
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      priClaim_q <= 1'b0;
      secClaim_q <= 1'b0;
      priDisc_q <= 1'b0;
      secDisc_q <= 1'b0;
      priCmd_q <= 4'h0;
      secCmd_q <= 4'h0;
      priAddr_q <= 32'h0;
      secAddr_q <= 32'h0;
      priFwd_q <= pbcf_pkg::PBCF_FWD_NONE;
      secFwd_q <= pbcf_pkg::PBCF_FWD_NONE;
    end else begin
      priClaim_q <= priClaim_d;
      secClaim_q <= secClaim_d;
      priDisc_q <= priDisc_d;
      secDisc_q <= secDisc_d;
      priCmd_q <= priCmd_d;
      secCmd_q <= secCmd_d;
      priAddr_q <= priAddr_d;
      secAddr_q <= secAddr_d;
      priFwd_q <= priFwd_d;
      secFwd_q <= secFwd_d;
    end
  end

  assign priClaim = priClaim_q;
  assign secClaim = secClaim_q;
  assign priDevselOff = !priClaim_q;
  assign secDevselOff = !secClaim_q;
  assign priDisconnect = priClaim_q && priDisc_q;
  assign secDisconnect = secClaim_q && secDisc_q;
  assign priFwd = priClaim_q ? priFwd_q : pbcf_pkg::PBCF_FWD_NONE;
  assign secFwd = secClaim_q ? secFwd_q : pbcf_pkg::PBCF_FWD_NONE;

  // two circular buffers: index 0 downstream (primary in), 1 upstream
  logic [pbcf_pkg::ENT_W-1:0] mem_q [2][pbcf_pkg::BUF_WORDS];
  logic [pbcf_pkg::BUF_AW:0] wp_q [2];
  logic [pbcf_pkg::BUF_AW:0] rp_q [2];
  logic [pbcf_pkg::BUF_AW:0] wp_d [2];
  logic [pbcf_pkg::BUF_AW:0] rp_d [2];
  logic push [2];
  logic pop [2];
  logic full [2];
  logic empty [2];
  logic [pbcf_pkg::ENT_W-1:0] wEnt [2];

  assign push[0] = priClaim_q && priDataValid && !full[0];
  assign push[1] = secClaim_q && secDataValid && !full[1];
  assign pop[0] = downPop && !empty[0];
  assign pop[1] = upPop && !empty[1];
  assign wEnt[0] = {priAddr_q, priData, priCmd_q, priByteEn};
  assign wEnt[1] = {secAddr_q, secData, secCmd_q, secByteEn};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gBuf
      assign full[g] = (wp_q[g][pbcf_pkg::BUF_AW] != rp_q[g][pbcf_pkg::BUF_AW])
        && (wp_q[g][pbcf_pkg::BUF_AW-1:0] == rp_q[g][pbcf_pkg::BUF_AW-1:0]);
      assign empty[g] = wp_q[g] == rp_q[g];
      // pointer next values
      always_comb begin
        wp_d[g] = push[g] ? wp_q[g] + 1'b1 : wp_q[g];
        rp_d[g] = pop[g] ? rp_q[g] + 1'b1 : rp_q[g];
      end
      // pointer and storage registers
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          wp_q[g] <= '0;
          rp_q[g] <= '0;
        end else begin
          wp_q[g] <= wp_d[g];
          rp_q[g] <= rp_d[g];
        end
        if (push[g]) begin
          mem_q[g][wp_q[g][pbcf_pkg::BUF_AW-1:0]] <= wEnt[g];
        end
      end
    end
  endgenerate

  assign downFull = full[0];
  assign upFull = full[1];
  assign downValid = !empty[0];
  assign upValid = !empty[1];
  assign downEntry = empty[0] ? '0 : mem_q[0][rp_q[0][pbcf_pkg::BUF_AW-1:0]];
  assign upEntry = empty[1] ? '0 : mem_q[1][rp_q[1][pbcf_pkg::BUF_AW-1:0]];

endmodule

// file: tb/pbcf_filter_assertions.sv
`timescale 1ns/100ps
// primary-side claim, forwarding and issue checks
module pbcf_filter_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic priAddrPhase,
  input wire logic [3:0] priCmd,
  input wire logic [31:0] priAddr,
  input wire logic priDecodeHit,
  input wire logic priVgaHit,
  input wire logic [3:0] priIssueCmd,
  input wire logic priIssueOk,
  input wire logic priClaim,
  input wire logic priDevselOff,
  input wire logic priDisconnect,
  input wire pbcf_pkg::pbcf_fwd_t priFwd
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_DEVSEL_INVERSE: assert property (priDevselOff != priClaim)
    else $error("device select not inverse of claim");
  AST_NO_CLAIM_UNSUPPORTED: assert property (priAddrPhase &&
    priCmd inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9} |=> !priClaim)
    else $error("unsupported command claimed");
  AST_CLAIM_IO_MEM: assert property (priAddrPhase &&
    priDecodeHit && priCmd inside {4'h2, 4'h3, 4'h6, 4'h7, [4'hC:4'hF]}
    |=> priClaim) else $error("supported command not claimed");
  AST_CLAIM_HOLDS: assert property (
    !priAddrPhase |=> $stable(priClaim))
    else $error("claim moved without address phase");
  AST_NO_ISSUE_CFGRD: assert property (
    priIssueCmd == 4'hA |-> !priIssueOk)
    else $error("config read allowed on primary");
  AST_NO_ISSUE_RESERVED: assert property (
    priIssueCmd inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9} |-> !priIssueOk)
    else $error("reserved command allowed as master");
  AST_DISCONNECT_UNALIGNED: assert property (priAddrPhase &&
    priDecodeHit && priCmd == 4'h6 && priAddr[1:0] != 2'h0
    |=> priDisconnect) else $error("no disconnect on unaligned address");
  AST_POSTED_MEMWR: assert property (priAddrPhase && priDecodeHit &&
    !priVgaHit && priCmd inside {4'h7, 4'hF}
    |=> priFwd == pbcf_pkg::PBCF_FWD_POSTED) else $error("write not posted");
endmodule
bind pbcf_filter pbcf_filter_chk u_chk (.*);

// file: tb/pbcf_far_drain.sv
`timescale 1ns/100ps
// far-side target that drains one buffer and stalls at random
module pbcf_far_drain (
  input wire logic clk_sys,
  input wire logic en,
  input wire logic valid,
  output logic pop
);
  integer seed = 32'h21C7C2CB;
  // take the head entry unless the target stalls this cycle
  always @(posedge clk_sys) begin
    pop <= en && valid && ($random(seed) & 3) != 0;
  end
endmodule

// file: tb/test_pci_bridge_command_filter.sv
`timescale 1ns/100ps
module test_pci_bridge_command_filter;
  logic clk_sys = 1'h0, rst = 1'h1, priAddrPhase = '0, secAddrPhase = '0;
  logic priDecodeHit = '0, secDecodeHit = '0, priVgaHit = '0, secVgaHit = '0;
  logic priDataValid = '0, secDataValid = '0, drainDown = '0, drainUp = '0;
  logic [3:0] priCmd = '0, secCmd = '0, priByteEn = '0, secByteEn = '0;
  logic [3:0] priIssueCmd = '0, secIssueCmd = '0;
  logic [1:0] priIssueAddrLo = '0, secIssueAddrLo = '0;
  logic [31:0] priAddr = '0, secAddr = '0, priData = '0, secData = '0;
  logic downPop, upPop, priClaim, secClaim, priDevselOff, secDevselOff;
  logic priDisconnect, secDisconnect, priIssueOk, secIssueOk, priSpecialConv;
  logic downFull, upFull, downValid, upValid;
  logic [71:0] downEntry, upEntry;
  pbcf_pkg::pbcf_fwd_t priFwd, secFwd;
  int fail_count = 0, samples_checked = 0;
  integer seed = 32'h21C7C2CB;
  logic [71:0] qd[$], qu[$];
  logic [31:0] lastAddr = '0;
  pbcf_filter u_dut (.*);
  pbcf_far_drain u_down (.clk_sys(clk_sys), .en(drainDown),
    .valid(downValid), .pop(downPop));
  pbcf_far_drain u_up (.clk_sys(clk_sys), .en(drainUp),
    .valid(upValid), .pop(upPop));
  // clock and hang guard
  always #50 clk_sys = ~clk_sys;
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    results();
  end
  // reference tables
  function automatic int claimOf(int b, int c, int lo);
    if (c == 10) return b == 0;
    if (c == 11) return b == 0 || lo == 1;
    return c inside {2, 3, 6, 7, [12:15]};
  endfunction
  function automatic int fwdOf(int c, int lo, int v);
    if (c == 7) return v ? 2 : 1;
    if (c == 3 || c == 11 && lo == 1) return 2;
    if (c == 15) return 1;
    return c inside {2, 6, 12, 14} ? 3 : -1;
  endfunction
  function automatic int okOf(int b, int c, int lo);
    if (c == 10) return b == 1;
    if (c == 11) return b == 1 || lo == 1;
    return c inside {1, 2, 3, 6, 7, [12:15]};
  endfunction
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t flag got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmpEnt(input logic [71:0] got, input logic [71:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t entry got %h exp %h", $time, got, exp);
    end
  endtask
  // one address phase on bus b, then check the registered decision
  task automatic addrPhase(input int b, c, lo, h, v);
    logic [31:0] a;
    int cl, fw;
    a = $random(seed);
    a[1:0] = lo[1:0];
    a[15:8] = a[16] ? 8'hFF : {1'b0, a[14:8]};
    lastAddr = a;
    @(posedge clk_sys);
    priAddrPhase <= b == 0;
    secAddrPhase <= b == 1;
    {priCmd, secCmd, priAddr, secAddr} <= {c[3:0], c[3:0], a, a};
    {priDecodeHit, secDecodeHit} <= {h[0], h[0]};
    {priVgaHit, secVgaHit} <= {v[0], v[0]};
    @(posedge clk_sys);
    {priAddrPhase, secAddrPhase} <= 2'h0;
    #1;
    cl = claimOf(b, c, lo) & h;
    fw = cl ? fwdOf(c, lo, v) : 0;
    cmp(b ? secClaim : priClaim, cl);
    cmp(b ? secDevselOff : priDevselOff, !cl);
    cmp(b ? secDisconnect : priDisconnect,
      cl && lo != 0 && (c < 10 || c > 11));
    if (fw >= 0) cmp(b ? secFwd : priFwd, fw);
    if (b == 0) cmp(priSpecialConv,
      cl && c == 11 && lo == 1 && a[16]);
  endtask
  // fill one buffer past full, then drain it through the far-side model
  task automatic fill(input int b);
    logic [39:0] e;
    addrPhase(b, 7, 0, 1, 0);
    for (int k = 0; k < 33; k++) begin
      e = {$random(seed), 4'h7, 4'(k)};
      if (k < 32 && b == 0) qd.push_back({lastAddr, e});
      if (k < 32 && b == 1) qu.push_back({lastAddr, e});
      @(posedge clk_sys);
      {priDataValid, secDataValid} <= {b == 0, b == 1};
      {priData, secData} <= {e[39:8], e[39:8]};
      {priByteEn, secByteEn} <= {e[3:0], e[3:0]};
    end
    @(posedge clk_sys);
    {priDataValid, secDataValid} <= 2'h0;
    {drainDown, drainUp} <= {b == 0, b == 1};
    #1 cmp(b ? upFull : downFull, 1);
    for (int k = 0; k < 400 && qd.size() + qu.size() > 0; k++)
      @(posedge clk_sys);
    @(posedge clk_sys);
    {drainDown, drainUp} <= 2'h0;
    #1 cmp(b ? upValid : downValid, 0);
    $display("test buffer %0d done", b);
  endtask
  // drained entries against the queued words, in order
  always @(negedge clk_sys) begin
    if (downPop && downValid) cmpEnt(downEntry, qd.pop_front());
    if (upPop && upValid) cmpEnt(upEntry, qu.pop_front());
  end
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    #1 cmp(priDevselOff, 1);
    for (int b = 0; b < 2; b++)
      for (int c = 0; c < 16; c++)
        for (int lo = 0; lo < 3; lo++) addrPhase(b, c, lo, 1, $random(seed) & 1);
    addrPhase(0, 6, 0, 0, 0);
    $display("test claim done");
    for (int c = 0; c < 64; c++) begin
      @(posedge clk_sys);
      {priIssueCmd, secIssueCmd} <= {c[5:2], c[5:2]};
      {priIssueAddrLo, secIssueAddrLo} <= {c[1:0], c[1:0]};
      @(negedge clk_sys);
      cmp(priIssueOk, okOf(0, c / 4, c % 4));
      cmp(secIssueOk, okOf(1, c / 4, c % 4));
    end
    $display("test issue done");
    addrPhase(0, 0, 0, 1, 0);
    @(posedge clk_sys);
    priDataValid <= 1'h1;
    @(posedge clk_sys);
    priDataValid <= 1'h0;
    @(posedge clk_sys);
    #1 cmp(downValid, 0);
    fill(0);
    fill(1);
    results();
  end
endmodule
